// ---- verilog/tpwm_pkg.sv ----
// Shared constants and encodings for the four-channel PWM timer.
// Assumes a single synchronous clock domain and byte-wide software writes.
package tpwm_pkg;
  localparam int TPWM_CHANNELS = 4;
  localparam int TPWM_WIDTH = 16;
  localparam logic [15:0] TPWM_MOD_RESET = 16'hFFFF;
  localparam logic [15:0] TPWM_CNT_RESET = 16'h0000;
  localparam logic [15:0] TPWM_CMP_RESET = 16'h0000;
  localparam logic [6:0] TPWM_PRE_RESET = 7'h00;
  localparam logic [2:0] TPWM_PS_EXT = 3'h7;
  // Mode select pair encodings.
  localparam logic [1:0] TPWM_MS_UNBUF = 2'h1;
  localparam logic [1:0] TPWM_MS_BUF = 2'h2;
  // Edge/level select pair encodings.
  localparam logic [1:0] TPWM_ELS_TOGGLE = 2'h1;
  localparam logic [1:0] TPWM_ELS_CLEAR = 2'h2;
  localparam logic [1:0] TPWM_ELS_SET = 2'h3;
  // Byte selects for split 16-bit writes.
  localparam int TPWM_BYTE_HI = 1;
  localparam int TPWM_BYTE_LO = 0;
endpackage : tpwm_pkg

// ---- verilog/tpwm_prescaler.sv ----
// Clock prescaler: produces a one-cycle counter tick at the selected division.
// Assumes ext_tick is already a synchronous one-cycle pulse.
module tpwm_prescaler
  import tpwm_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic clear,
  input wire logic run,
  input wire logic [2:0] prescale_select,
  input wire logic ext_tick,
  output logic tick
);
  typedef struct packed {
    logic [6:0] div;
  } tpwm_pre_state_t;

  tpwm_pre_state_t s_q;
  tpwm_pre_state_t s_d;
  logic [6:0] mask;

  always_comb
  begin
    s_d = s_q;
    mask = 7'((8'h01 << prescale_select) - 8'h01);
    tick = 1'b0;
    if (clear)
    begin
      s_d.div = TPWM_PRE_RESET;
    end
    else if (run)
    begin
      if (prescale_select == TPWM_PS_EXT)
      begin
        tick = ext_tick;
      end
      else
      begin
        tick = (s_q.div & mask) == mask;
        s_d.div = tick ? TPWM_PRE_RESET : 7'(s_q.div + 7'h01);
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      s_q <= '{div: TPWM_PRE_RESET};
    end
    else
    begin
      s_q <= s_d;
    end
  end
endmodule : tpwm_prescaler

// ---- verilog/tpwm_byte_reg.sv ----
// A 16-bit register written as a high and a low byte.
// Assumes the writer pulses one byte strobe per cycle.
module tpwm_byte_reg
  import tpwm_pkg::*;
#(
  parameter logic [15:0] RESET_VALUE = 16'h0000
)
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic wr_hi,
  input wire logic wr_lo,
  input wire logic [7:0] wr_data,
  output logic [15:0] value,
  output logic hi_pending
);
  typedef struct packed {
    logic [15:0] value;
    logic pend;
  } tpwm_breg_state_t;

  tpwm_breg_state_t s_q;
  tpwm_breg_state_t s_d;

  always_comb
  begin
    s_d = s_q;
    if (wr_hi)
    begin
      s_d.value[15:8] = wr_data;
      s_d.pend = 1'b1;
    end
    if (wr_lo)
    begin
      s_d.value[7:0] = wr_data;
      s_d.pend = 1'b0;
    end
  end

  assign value = s_q.value;
  assign hi_pending = s_q.pend;

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      s_q <= '{value: RESET_VALUE, pend: 1'b0};
    end
    else
    begin
      s_q <= s_d;
    end
  end
endmodule : tpwm_byte_reg

// ---- verilog/timer_pwm_channels.sv ----
// Four-channel 16-bit timer with PWM, output compare and linked-pair buffering.
// Assumes all control inputs are synchronous to clk_sys and write strobes are one-cycle pulses.
//
// Overview of operation
// - Toggle-on-overflow toggles channel pin when counter rolls over from modulo value to zero.
// - Pulse width runs from overflow to compare match on channel value.
// - Period equals modulo plus one counter ticks at selected prescale.
// - Compare value 0x80 with modulo 0xFF gives half duty.
// - Unbuffered channels compare against live channel register directly.
// - Channel flag at pulse end, overflow flag at period end.
// - Pair 0/1 buffer enable links channels, output on pin 0, ch0 first.
// - Writing other channel of pair takes control at next overflow.
// - Lower channel controls pair; upper control unused, upper pin released.
// - Pair 2/3 buffer enable links channels, output on pin 2, ch2 first.
// - Mode select 0:1 unbuffered, 1:0 buffered.
// - Edge/level 1:0 clears on compare, 1:1 sets on compare.
// - Buffer enable of channels 0 and 2 overrides lower mode bit.
// - Without toggle-on-overflow, clear-on-compare re-forces pin low, giving zero duty.
// - Max-duty set with toggle-on-overflow clear drives full duty.
// - Overflow flag set on rollover to zero; interrupt when enabled.
// - Channel flag set on compare; interrupt when channel enable set.
// - On the tick at modulo value, set overflow flag and restart from zero.
// - Counter reset bit clears counter and prescaler, touches nothing else.
// - Modulo high-byte write inhibits overflow flag until low byte written.
////////////////////////////////////////////////////////////////////////////////
module timer_pwm_channels
  import tpwm_pkg::*;
#(
  parameter int NCH = TPWM_CHANNELS
)
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic counter_stop,
  input wire logic counter_reset,
  input wire logic [2:0] prescale_select,
  input wire logic ext_clock_tick,
  input wire logic overflow_irq_enable,
  input wire logic overflow_flag_clear,
  input wire logic modulo_wr_hi,
  input wire logic modulo_wr_lo,
  input wire logic [7:0] wr_data,
  input wire logic [NCH-1:0] compare_wr_hi,
  input wire logic [NCH-1:0] compare_wr_lo,
  input wire logic [2*NCH-1:0] channel_mode_select,
  input wire logic [2*NCH-1:0] edge_level_select,
  input wire logic [NCH-1:0] toggle_on_overflow,
  input wire logic [NCH-1:0] channel_max_duty,
  input wire logic [NCH-1:0] channel_irq_enable,
  input wire logic [NCH-1:0] channel_flag_clear,
  output logic [15:0] counter_value,
  output logic overflow_flag,
  output logic overflow_irq,
  output logic [NCH-1:0] channel_flag,
  output logic [NCH-1:0] channel_irq,
  output logic [NCH-1:0] channel_pin_out,
  output logic [NCH-1:0] channel_pin_oe
);
  typedef struct packed {
    logic [15:0] count;
    logic ovf_flag;
    logic ovf_irq;
    logic [NCH-1:0] ch_flag;
    logic [NCH-1:0] ch_irq;
    logic [NCH-1:0] pin;
    logic [NCH-1:0] oe;
    logic [1:0] sel_upper;
    logic [1:0] pend_upper;
    logic [1:0] pend_lower;
  } tpwm_state_t;

  tpwm_state_t s_q;
  tpwm_state_t s_d;

  logic tick;
  logic [15:0] modulo_value;
  logic modulo_hi_pending;
  logic [15:0] compare_value [NCH];
  logic [NCH-1:0] compare_hi_pending;
  logic [NCH-1:0] compare_wr_done;
  logic [NCH-1:0] linked;
  logic [NCH-1:0] active;
  logic [15:0] eff_cmp [NCH];
  logic [NCH/2-1:0] pair_buf;
  logic at_modulo;
  logic overflow_evt;
  logic [15:0] cnt_next;
  logic [NCH-1:0] cmp_hit;
  logic [NCH-1:0] ovf_toggle;
  logic [NCH-1:0] force_full;

  ////////////////////////////////////////////////////////////////////////////////
  // prescaler clear
  tpwm_prescaler u_pre (
    .clk_sys(clk_sys),
    .rst(rst),
    .clear(counter_reset),
    .run(~counter_stop),
    .prescale_select(prescale_select),
    .ext_tick(ext_clock_tick),
    .tick(tick)
  );

  tpwm_byte_reg #(.RESET_VALUE(TPWM_MOD_RESET)) u_mod (
    .clk_sys(clk_sys),
    .rst(rst),
    .wr_hi(modulo_wr_hi),
    .wr_lo(modulo_wr_lo),
    .wr_data(wr_data),
    .value(modulo_value),
    .hi_pending(modulo_hi_pending)
  );

  genvar gi;
  generate
    for (gi = 0; gi < NCH; gi++)
    begin : g_cmp
      tpwm_byte_reg #(.RESET_VALUE(TPWM_CMP_RESET)) u_cmp (
        .clk_sys(clk_sys),
        .rst(rst),
        .wr_hi(compare_wr_hi[gi]),
        .wr_lo(compare_wr_lo[gi]),
        .wr_data(wr_data),
        .value(compare_value[gi]),
        .hi_pending(compare_hi_pending[gi])
      );
      assign compare_wr_done[gi] = compare_wr_lo[gi] | compare_wr_hi[gi];

      assign linked[gi] = pair_buf[gi/2];
      if ((gi % 2) == 0)
      begin : g_lower
        // The buffer enable is the high mode bit of the lower channel and beats its low bit.
        assign pair_buf[gi/2] = channel_mode_select[2*gi+1];
        assign active[gi] = linked[gi] || (channel_mode_select[2*gi+:2] == TPWM_MS_UNBUF);
        assign eff_cmp[gi] = (linked[gi] && s_q.sel_upper[gi/2]) ? compare_value[gi+1]
          : compare_value[gi];
      end
      else
      begin : g_upper
        assign active[gi] = !linked[gi] && (channel_mode_select[2*gi+:2] == TPWM_MS_UNBUF);
        assign eff_cmp[gi] = compare_value[gi];
      end

      // match on reach
      // Matching on the next count makes a compare value of N give exactly N ticks of pulse.
      assign cmp_hit[gi] = active[gi] & tick & (cnt_next == eff_cmp[gi]);
      assign ovf_toggle[gi] = active[gi] & overflow_evt & toggle_on_overflow[gi];
      assign force_full[gi] = active[gi] & channel_max_duty[gi] & ~toggle_on_overflow[gi];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // modulo match
  assign at_modulo = (s_q.count == modulo_value);
  assign overflow_evt = tick & at_modulo;

  // next count
  // The prescaler holds tick low during a counter reset, so the clear always wins.
  always_comb
  begin
    cnt_next = s_q.count;
    if (counter_reset)
    begin
      cnt_next = TPWM_CNT_RESET;
    end
    else if (tick)
    begin
      cnt_next = at_modulo ? TPWM_CNT_RESET : 16'(s_q.count + 16'h0001);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    s_d = s_q;
    s_d.count = cnt_next;

    // overflow flag, set wins over clear
    if (overflow_flag_clear)
    begin
      s_d.ovf_flag = 1'b0;
    end
    if (overflow_evt && !modulo_hi_pending)
    begin
      s_d.ovf_flag = 1'b1;
    end
    s_d.ovf_irq = s_d.ovf_flag & overflow_irq_enable;

    for (int p = 0; p < NCH / 2; p++)
    begin
      if (!pair_buf[p])
      begin
        s_d.sel_upper[p] = 1'b0;
        s_d.pend_upper[p] = 1'b0;
        s_d.pend_lower[p] = 1'b0;
      end
      else
      begin
        if (compare_wr_done[2*p+1])
        begin
          s_d.pend_upper[p] = 1'b1;
          s_d.pend_lower[p] = 1'b0;
        end
        if (compare_wr_done[2*p])
        begin
          s_d.pend_lower[p] = 1'b1;
          s_d.pend_upper[p] = 1'b0;
        end
        if (overflow_evt && s_q.pend_upper[p])
        begin
          s_d.sel_upper[p] = 1'b1;
          s_d.pend_upper[p] = 1'b0;
        end
        else if (overflow_evt && s_q.pend_lower[p])
        begin
          s_d.sel_upper[p] = 1'b0;
          s_d.pend_lower[p] = 1'b0;
        end
      end
    end

    for (int i = 0; i < NCH; i++)
    begin
      s_d.oe[i] = active[i];
      if (cmp_hit[i])
      begin
        case (edge_level_select[2*i+:2])
          TPWM_ELS_CLEAR: s_d.pin[i] = 1'b0;
          TPWM_ELS_SET: s_d.pin[i] = 1'b1;
          TPWM_ELS_TOGGLE: s_d.pin[i] = ~s_q.pin[i];
          default: s_d.pin[i] = s_q.pin[i];
        endcase
      end
      if (ovf_toggle[i])
      begin
        s_d.pin[i] = ~s_d.pin[i];
      end
      if (force_full[i])
      begin
        s_d.pin[i] = 1'b1;
      end
      // channel flag, set wins over clear
      if (channel_flag_clear[i])
      begin
        s_d.ch_flag[i] = 1'b0;
      end
      if (cmp_hit[i])
      begin
        s_d.ch_flag[i] = 1'b1;
      end
      s_d.ch_irq[i] = s_d.ch_flag[i] & channel_irq_enable[i];
    end
  end

  assign counter_value = s_q.count;
  assign overflow_flag = s_q.ovf_flag;
  assign overflow_irq = s_q.ovf_irq;
  assign channel_flag = s_q.ch_flag;
  assign channel_irq = s_q.ch_irq;
  assign channel_pin_out = s_q.pin;
  assign channel_pin_oe = s_q.oe;

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end
endmodule : timer_pwm_channels

// ---- testbench/tpwm_asserts.sv ----
// Port-level checks on the four-channel PWM timer.
// Assumes one clock domain; only the counter step check relies on a prescale of one.
module tpwm_asserts
  import tpwm_pkg::*;
#(
  parameter int NCH = 4
)
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic counter_stop,
  input wire logic counter_reset,
  input wire logic [2:0] prescale_select,
  input wire logic overflow_irq_enable,
  input wire logic [2*NCH-1:0] channel_mode_select,
  input wire logic [2*NCH-1:0] edge_level_select,
  input wire logic [NCH-1:0] toggle_on_overflow,
  input wire logic [NCH-1:0] channel_max_duty,
  input wire logic [NCH-1:0] channel_irq_enable,
  input wire logic [15:0] counter_value,
  input wire logic overflow_flag,
  input wire logic overflow_irq,
  input wire logic [NCH-1:0] channel_flag,
  input wire logic [NCH-1:0] channel_irq,
  input wire logic [NCH-1:0] channel_pin_out,
  input wire logic [NCH-1:0] channel_pin_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  sequence s_link01;
    channel_mode_select[1] ##1 channel_mode_select[1];
  endsequence
  sequence s_link23;
    channel_mode_select[5] ##1 channel_mode_select[5];
  endsequence
  property p_link01;
    s_link01 |-> channel_pin_oe[0] && !channel_pin_oe[1];
  endproperty
  property p_link23;
    s_link23 |-> channel_pin_oe[2] && !channel_pin_oe[3];
  endproperty
  property p_ovf_irq;
    overflow_irq |-> overflow_flag && $past(overflow_irq_enable);
  endproperty
  property p_ch_irq;
    channel_irq[0] |-> channel_flag[0] && $past(channel_irq_enable[0]);
  endproperty
  property p_roll;
    $rose(overflow_flag) |-> counter_value == 16'h0000;
  endproperty
  property p_clr;
    counter_reset |=> counter_value == TPWM_CNT_RESET;
  endproperty
  property p_step;
    !counter_stop && !$past(counter_stop) && !counter_reset && prescale_select == 3'h0
      |=> counter_value == $past(counter_value) + 16'h0001 || counter_value == 16'h0000;
  endproperty
  property p_max;
    channel_max_duty[2] && !toggle_on_overflow[2] |=> channel_pin_out[2];
  endproperty
  property p_zero;
    !toggle_on_overflow[1] && !channel_max_duty[1] && !channel_pin_out[1]
      && edge_level_select[3:2] == TPWM_ELS_CLEAR |=> !channel_pin_out[1];
  endproperty
  property p_flag;
    $fell(channel_pin_out[0]) && counter_value != 16'h0000
      && edge_level_select[1:0] == TPWM_ELS_CLEAR |-> channel_flag[0];
  endproperty
  a_link01: assert property (p_link01) else $error("pair 0/1 pins wrong");
  a_link23: assert property (p_link23) else $error("pair 2/3 pins wrong");
  a_ovf_irq: assert property (p_ovf_irq) else $error("overflow irq wrong");
  a_ch_irq: assert property (p_ch_irq) else $error("channel irq wrong");
  a_roll: assert property (p_roll) else $error("no rollover to zero");
  a_clr: assert property (p_clr) else $error("counter not cleared");
  a_step: assert property (p_step) else $error("counter step wrong");
  a_max: assert property (p_max) else $error("full duty lost");
  a_zero: assert property (p_zero) else $error("zero duty lost");
  a_flag: assert property (p_flag) else $error("no flag at pulse end");
endmodule : tpwm_asserts

bind timer_pwm_channels tpwm_asserts #(.NCH(NCH)) u_chk (.clk_sys(clk_sys), .rst(rst),
  .counter_stop(counter_stop), .counter_reset(counter_reset),
  .prescale_select(prescale_select), .overflow_irq_enable(overflow_irq_enable),
  .channel_mode_select(channel_mode_select), .edge_level_select(edge_level_select),
  .toggle_on_overflow(toggle_on_overflow), .channel_max_duty(channel_max_duty),
  .channel_irq_enable(channel_irq_enable), .counter_value(counter_value),
  .overflow_flag(overflow_flag), .overflow_irq(overflow_irq), .channel_flag(channel_flag),
  .channel_irq(channel_irq), .channel_pin_out(channel_pin_out),
  .channel_pin_oe(channel_pin_oe));

// ---- testbench/tb.sv ----
// Self-checking bench for the four-channel PWM timer.
// Assumes prescale one, one count per clk_sys cycle, outside the prescaler test.
module tb;
  import tpwm_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin errors++; \
  $display("unexpected %0t: got %h want %h", $time, a, b); end end
  localparam logic [15:0] MOD = 16'h00FF;
  localparam logic [15:0] CMP = 16'h0080;
  localparam logic [15:0] CMP1 = 16'h0040;
  localparam int P = int'(MOD) + 1;
  int errors = 0;
  int tests_run = 0;
  logic clk_sys, rst, counter_stop, counter_reset, ext_clock_tick, overflow_irq_enable;
  logic overflow_flag_clear, modulo_wr_hi, modulo_wr_lo, overflow_flag, overflow_irq;
  logic [2:0] prescale_select;
  logic [7:0] wr_data, channel_mode_select, edge_level_select;
  logic [3:0] compare_wr_hi, compare_wr_lo, toggle_on_overflow, channel_max_duty;
  logic [3:0] channel_irq_enable, channel_flag_clear, channel_flag, channel_irq;
  logic [3:0] channel_pin_out, channel_pin_oe;
  logic [15:0] counter_value;
  timer_pwm_channels dut (.clk_sys, .rst, .counter_stop, .counter_reset, .prescale_select,
    .ext_clock_tick, .overflow_irq_enable, .overflow_flag_clear, .modulo_wr_hi,
    .modulo_wr_lo, .wr_data, .compare_wr_hi, .compare_wr_lo, .channel_mode_select,
    .edge_level_select, .toggle_on_overflow, .channel_max_duty, .channel_irq_enable,
    .channel_flag_clear, .counter_value, .overflow_flag, .overflow_irq, .channel_flag,
    .channel_irq, .channel_pin_out, .channel_pin_oe);
  ////////////////////////////////////////////////////////////////////////////////
  task automatic test_done();
    $display("checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : test_done
  // A negative channel selects the modulo register.
  task automatic wr16(input int ch, input logic [15:0] v);
    @(posedge clk_sys);
    wr_data <= v[15:8];
    if (ch < 0) modulo_wr_hi <= 1'b1;
    else compare_wr_hi[ch] <= 1'b1;
    @(posedge clk_sys);
    wr_data <= v[7:0];
    modulo_wr_hi <= 1'b0;
    compare_wr_hi <= 4'h0;
    if (ch < 0) modulo_wr_lo <= 1'b1;
    else compare_wr_lo[ch] <= 1'b1;
    @(posedge clk_sys);
    modulo_wr_lo <= 1'b0;
    compare_wr_lo <= 4'h0;
  endtask : wr16
  task automatic wait_ovf();
    @(posedge clk_sys);
    overflow_flag_clear <= 1'b1;
    @(posedge clk_sys);
    overflow_flag_clear <= 1'b0;
    #1;
    for (int i = 0; i < 3 * P && overflow_flag !== 1'b1; i++)
    begin
      @(posedge clk_sys);
      #1;
    end
    `CHK(overflow_flag, 1'b1)
  endtask : wait_ovf
  // Sampling a whole period makes the count independent of phase.
  task automatic measure(output int h[4]);
    h = '{0, 0, 0, 0};
    repeat (P)
    begin
      @(posedge clk_sys);
      #1;
      for (int c = 0; c < 4; c++) h[c] += int'(channel_pin_out[c] === 1'b1);
    end
  endtask : measure
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  initial
  begin
    #100us;
    errors++;
    $display("unexpected %0t: watchdog expired", $time);
    test_done();
  end
  initial
  begin
    int h[4];
    time t0;
    {rst, counter_stop} = 2'h3;
    {counter_reset, ext_clock_tick, overflow_irq_enable, overflow_flag_clear} = 4'h0;
    {modulo_wr_hi, modulo_wr_lo, prescale_select, wr_data} = '0;
    {compare_wr_hi, compare_wr_lo, toggle_on_overflow, channel_max_duty} = '0;
    {channel_irq_enable, channel_flag_clear, channel_mode_select, edge_level_select} = '0;
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    // stop, reset, modulo, compare, mode, release.
    @(posedge clk_sys);
    counter_reset <= 1'b1;
    @(posedge clk_sys);
    counter_reset <= 1'b0;
    wr16(-1, MOD);
    for (int c = 0; c < 4; c++) wr16(c, c == 3 ? CMP1 : CMP);
    channel_mode_select <= 8'h55;
    edge_level_select <= 8'hEA;
    toggle_on_overflow <= 4'h9;
    channel_max_duty <= 4'h4;
    channel_irq_enable <= 4'h1;
    overflow_irq_enable <= 1'b1;
    counter_stop <= 1'b0;
    wait_ovf();
    t0 = $time;
    wait_ovf();
    `CHK(int'(($time - t0) / 8), P)
    measure(h);
    `CHK(h[0], int'(CMP))
    `CHK(h[1], 0)
    `CHK(h[2], P)
    `CHK(h[3], P - int'(CMP1))
    `CHK(channel_flag[1:0], 2'h3)
    `CHK(channel_irq[1:0], 2'h1)
    `CHK(overflow_irq, 1'b1)
    `CHK(channel_pin_oe, 4'hF)
    $display("unbuffered test done");
    @(posedge clk_sys);
    wr_data <= 8'h00;
    modulo_wr_hi <= 1'b1;
    overflow_flag_clear <= 1'b1;
    @(posedge clk_sys);
    modulo_wr_hi <= 1'b0;
    overflow_flag_clear <= 1'b0;
    repeat (P + 8) @(posedge clk_sys);
    #1;
    `CHK(overflow_flag, 1'b0)
    @(posedge clk_sys);
    wr_data <= 8'hFF;
    modulo_wr_lo <= 1'b1;
    @(posedge clk_sys);
    modulo_wr_lo <= 1'b0;
    wait_ovf();
    $display("modulo inhibit test done");
    @(posedge clk_sys);
    channel_mode_select <= 8'h67;
    wr16(1, CMP1);
    wait_ovf();
    measure(h);
    `CHK(h[0], int'(CMP1))
    `CHK(channel_pin_oe, 4'h5)
    wr16(0, CMP);
    wait_ovf();
    measure(h);
    `CHK(h[0], int'(CMP))
    $display("buffered test done");
    @(posedge clk_sys);
    prescale_select <= 3'h1;
    wait_ovf();
    t0 = $time;
    wait_ovf();
    `CHK(int'(($time - t0) / 8), 2 * P)
    @(posedge clk_sys);
    prescale_select <= 3'h0;
    $display("prescaler test done");
    @(posedge clk_sys);
    counter_reset <= 1'b1;
    channel_flag_clear <= 4'h2;
    @(posedge clk_sys);
    counter_reset <= 1'b0;
    channel_flag_clear <= 4'h0;
    #1;
    `CHK(counter_value, 16'h0000)
    `CHK(overflow_flag, 1'b1)
    `CHK(channel_flag, 4'hD)
    $display("counter reset test done");
    test_done();
  end
endmodule : tb
